// >>> hdl/burst_ramp_pkg.sv
package burst_ramp_pkg;

  // ==========================================================================
  // Timing of the internal cycle
  // ==========================================================================
  localparam int MCLK_PER_CYCLE = 6;
  localparam int CORE_PERIOD_PS = 8000;

  // Trigger-to-point delays are thirteen sixths of an internal cycle.
  localparam int BURST_TRIGGER_PT_SIXTHS = 13;
  localparam logic [5:0] BURST_TRIGGER_PT_CYC = 6'(BURST_TRIGGER_PT_SIXTHS / MCLK_PER_CYCLE);
  localparam logic [2:0] BURST_TRIGGER_PT_SUB = 3'(BURST_TRIGGER_PT_SIXTHS % MCLK_PER_CYCLE);
  localparam logic [5:0] B_TO_C_CYC = 6'h12;
  localparam logic [5:0] E_TO_G_CYC = 6'h26;
  localparam logic [2:0] SUB_LAST = 3'(MCLK_PER_CYCLE - 1);
  localparam logic [2:0] SUB_ZERO = 3'h0;

  // ==========================================================================
  // Quick-restart pulse widths
  // ==========================================================================
  localparam int QRS_MIN_PS = 77000;
  localparam int QRS_MAX_PS = 769000;
  localparam int NOQRS_MIN_PS = 1000000;
  localparam int QRS_MIN_CYC = (QRS_MIN_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int QRS_MAX_CYC = QRS_MAX_PS / CORE_PERIOD_PS;
  localparam int NOQRS_MIN_CYC = (NOQRS_MIN_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int LOW_CNT_W = 8;
  localparam logic [LOW_CNT_W-1:0] LOW_CNT_MAX = 8'hff;
  localparam logic [LOW_CNT_W-1:0] LOW_QRS_MIN = LOW_CNT_W'(QRS_MIN_CYC);
  localparam logic [LOW_CNT_W-1:0] LOW_QRS_MAX = LOW_CNT_W'(QRS_MAX_CYC);
  localparam logic [LOW_CNT_W-1:0] LOW_NOQRS = LOW_CNT_W'(NOQRS_MIN_CYC);

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_UP_B,
    ST_UP_C,
    ST_HIGH,
    ST_DN_E,
    ST_DN_G
  } ramp_state_t;

endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : gen_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  // The first stage feeds only the second one.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pin_sync

// >>> hdl/burst_ramp_trigger_sequencer.sv
// Behaviour
// - Ramp timing counts in an internal cycle of six master clock periods.
// - A trigger low pulse of 0.077 to 0.769 us is taken as a quick-restart request.
// - A trigger low pulse of 1.0 us or more is no quick restart and gives a normal ramp-down.
// - Point B follows a rising trigger edge after thirteen sixths of an internal cycle.
// - Point C follows point B after exactly 18 internal cycles.
// - Point E follows a falling trigger edge after thirteen sixths of an internal cycle.
// - Point G follows point E after exactly 38 internal cycles, and only then may a ramp-up resume.
// - A serial transfer completes on one more rising serial clock edge after the strobe goes high.
// - A rising trigger edge starts the up-ramp and a falling one starts the down-ramp.
// - After a quick-restart request the regulator is kept partially active.
// - A power level loaded between E and G is applied to the next burst.
`timescale 1ns/100ps
module burst_ramp_trigger_sequencer
  import burst_ramp_pkg::*;
#(
  parameter int LEVEL_W = 8
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic master_clock_input_in,
  input wire logic burst_trigger_in,
  input wire logic power_down_input_in,
  input wire logic serial_clk_in,
  input wire logic serial_strobe_in,
  input wire logic serial_data_in,
  output logic ramp_up_out,
  output logic ramp_down_out,
  output logic point_b_out,
  output logic point_c_out,
  output logic point_e_out,
  output logic point_g_out,
  output logic regulator_partial_out,
  output logic [LEVEL_W-1:0] power_level_out
);

  // The shift register keeps its lower bits on each shift, so it needs two bits at least.
  if (LEVEL_W < 2 || LEVEL_W > 16) begin : gen_bad_level_w
    $error("LEVEL_W must be 2 to 16");
  end

  // ==========================================================================
  // Pin synchronisation and edge detection
  // ==========================================================================
  logic [5:0] pins_s;
  logic mclk_s, burst_trigger_s, pd_s, sclk_s, strobe_s, sdata_s;
  logic mclk_d_r, burst_trigger_d_r, sclk_d_r;

  pin_sync #(.WIDTH(6)) u_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in({master_clock_input_in, burst_trigger_in, power_down_input_in,
               serial_clk_in, serial_strobe_in, serial_data_in}),
    .sync_out(pins_s)
  );

  assign {mclk_s, burst_trigger_s, pd_s, sclk_s, strobe_s, sdata_s} = pins_s;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mclk_d_r <= 1'b0;
      burst_trigger_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      mclk_d_r <= mclk_s;
      burst_trigger_d_r <= burst_trigger_s;
      sclk_d_r <= sclk_s;
    end
  end

  wire mclk_rise = mclk_s & ~mclk_d_r;
  wire burst_trigger_rise = burst_trigger_s & ~burst_trigger_d_r;
  wire burst_trigger_fall = ~burst_trigger_s & burst_trigger_d_r;
  wire sclk_rise = sclk_s & ~sclk_d_r;

  // ==========================================================================
  // Serial power level load
  // ==========================================================================
  logic [LEVEL_W-1:0] shift_r, shadow_r;
  logic armed_r;
  wire shift_en = sclk_rise & ~strobe_s;
  wire load_done = sclk_rise & strobe_s & armed_r;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_r <= '0;
      shadow_r <= '0;
      armed_r <= 1'b0;
    end else begin
      if (shift_en) shift_r <= {shift_r[LEVEL_W-2:0], sdata_s};
      if (load_done) shadow_r <= shift_r;
      armed_r <= shift_en | (armed_r & ~load_done);
    end
  end

  // ==========================================================================
  // Trigger low-pulse measurement
  // ==========================================================================
  logic [LOW_CNT_W-1:0] low_cnt_r;
  logic qrs_r;
  wire low_in_qrs = (low_cnt_r >= LOW_QRS_MIN) && (low_cnt_r <= LOW_QRS_MAX);
  wire qrs_seen = burst_trigger_rise & low_in_qrs & ~pd_s;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_cnt_r <= '0;
    end else if (burst_trigger_fall) begin
      low_cnt_r <= 8'h01;
    end else if (!burst_trigger_s && low_cnt_r != LOW_CNT_MAX) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end

  // ==========================================================================
  // Internal cycle counter
  // ==========================================================================
  ramp_state_t st_r, st_nxt;
  logic [5:0] cyc_r, cyc_nxt;
  logic [2:0] sub_r, sub_nxt;
  logic pending_r;

  wire sub_wrap = (sub_r == SUB_LAST);
  assign sub_nxt = !mclk_rise ? sub_r : (sub_wrap ? SUB_ZERO : sub_r + 3'h1);
  assign cyc_nxt = (mclk_rise && sub_wrap) ? cyc_r + 6'h01 : cyc_r;

  wire hit_burst_trigger_pt = mclk_rise && cyc_nxt == BURST_TRIGGER_PT_CYC && sub_nxt == BURST_TRIGGER_PT_SUB;
  wire hit_c = mclk_rise && cyc_nxt == B_TO_C_CYC && sub_nxt == SUB_ZERO;
  wire hit_g = mclk_rise && cyc_nxt == E_TO_G_CYC && sub_nxt == SUB_ZERO;

  // ==========================================================================
  // Ramp sequencer
  // ==========================================================================
  wire up_state = (st_r == ST_UP_B) || (st_r == ST_UP_C) || (st_r == ST_HIGH);
  wire dn_state = (st_r == ST_DN_E) || (st_r == ST_DN_G);
  // A rise seen in the very cycle of point G must not be lost between DN_G and IDLE.
  wire start_up = (st_r == ST_IDLE && burst_trigger_rise) ||
                  (st_r == ST_DN_G && hit_g && (pending_r || burst_trigger_rise));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (burst_trigger_rise) st_nxt = ST_UP_B;
      ST_UP_B: if (burst_trigger_fall) st_nxt = ST_DN_E;
        else if (hit_burst_trigger_pt) st_nxt = ST_UP_C;
      ST_UP_C: if (burst_trigger_fall) st_nxt = ST_DN_E;
        else if (hit_c) st_nxt = ST_HIGH;
      ST_HIGH: if (burst_trigger_fall) st_nxt = ST_DN_E;
      ST_DN_E: if (hit_burst_trigger_pt) st_nxt = ST_DN_G;
      ST_DN_G: if (hit_g) st_nxt = (pending_r || burst_trigger_rise) ? ST_UP_B : ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
    if (pd_s) st_nxt = ST_IDLE;
  end

  // Phases restart the count so each point is timed from its own start.
  wire restart_cnt = (st_nxt != st_r);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= ST_IDLE;
      cyc_r <= '0;
      sub_r <= '0;
    end else begin
      st_r <= st_nxt;
      cyc_r <= restart_cnt ? 6'h00 : cyc_nxt;
      sub_r <= restart_cnt ? SUB_ZERO : sub_nxt;
    end
  end

  // A rising edge during the down-ramp waits for G; a later fall cancels it.
  wire pend_set = dn_state & burst_trigger_rise & ~pd_s;
  wire pend_clr = pd_s | burst_trigger_fall | (st_r == ST_DN_G && hit_g);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= pend_set | (pending_r & ~pend_clr);
    end
  end

  // The partial hold lasts until the next up-ramp reaches point B.
  wire qrs_clr = pd_s | (st_r == ST_UP_B && st_nxt == ST_UP_C);
  wire qrs_nxt = qrs_seen | (qrs_r & ~qrs_clr);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      qrs_r <= 1'b0;
    end else begin
      qrs_r <= qrs_nxt;
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  wire up_nxt = (st_nxt == ST_UP_B) || (st_nxt == ST_UP_C) || (st_nxt == ST_HIGH);
  wire dn_nxt = (st_nxt == ST_DN_E) || (st_nxt == ST_DN_G);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ramp_up_out <= 1'b0;
      ramp_down_out <= 1'b0;
      point_b_out <= 1'b0;
      point_c_out <= 1'b0;
      point_e_out <= 1'b0;
      point_g_out <= 1'b0;
      regulator_partial_out <= 1'b0;
      power_level_out <= '0;
    end else begin
      ramp_up_out <= up_nxt;
      ramp_down_out <= dn_nxt;
      point_b_out <= (st_r == ST_UP_B) && (st_nxt == ST_UP_C);
      point_c_out <= (st_r == ST_UP_C) && (st_nxt == ST_HIGH);
      point_e_out <= (st_r == ST_DN_E) && (st_nxt == ST_DN_G);
      point_g_out <= (st_r == ST_DN_G) && hit_g && !pd_s;
      regulator_partial_out <= qrs_nxt;
      if (start_up && !pd_s) power_level_out <= shadow_r;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  cycle_wrap_a: assert property (mclk_rise && sub_r == SUB_LAST |=> sub_r == SUB_ZERO)
    else $error("internal cycle did not wrap after six master edges");
  qrs_detect_a: assert property (burst_trigger_rise && low_cnt_r >= LOW_QRS_MIN &&
    low_cnt_r <= LOW_QRS_MAX && !pd_s |=> qrs_r)
    else $error("short trigger low pulse not taken as quick restart");
  no_qrs_a: assert property (burst_trigger_rise && low_cnt_r >= LOW_NOQRS && !qrs_r |=> !qrs_r)
    else $error("long trigger low pulse taken as quick restart");
  point_b_a: assert property (st_r == ST_UP_B && mclk_rise && !burst_trigger_fall && !pd_s &&
    cyc_r == BURST_TRIGGER_PT_CYC && sub_r == BURST_TRIGGER_PT_SUB - 3'h1 |=> st_r == ST_UP_C && point_b_out)
    else $error("point B not reached after thirteen master edges");
  point_c_a: assert property ($rose(point_b_out) |->
    st_r == ST_UP_C && cyc_r == '0 && sub_r == SUB_ZERO)
    else $error("B to C count did not start at point B");
  point_c_time_a: assert property (st_r == ST_UP_C && hit_c && !burst_trigger_fall && !pd_s
    |=> st_r == ST_HIGH)
    else $error("point C not reached after eighteen internal cycles");
  point_e_a: assert property (st_r == ST_DN_E && mclk_rise && !pd_s &&
    cyc_r == BURST_TRIGGER_PT_CYC && sub_r == BURST_TRIGGER_PT_SUB - 3'h1 |=> st_r == ST_DN_G)
    else $error("point E not reached after thirteen master edges");
  point_g_a: assert property (st_r == ST_DN_G && !hit_g |=> !ramp_up_out)
    else $error("ramp-up resumed before point G");
  serial_done_a: assert property (load_done |=> shadow_r == $past(shift_r))
    else $error("serial transfer did not complete on the closing edge");
  up_start_a: assert property (st_r == ST_IDLE && burst_trigger_rise && !pd_s |=> ramp_up_out)
    else $error("rising trigger did not start the up-ramp");
  down_start_a: assert property (up_state && burst_trigger_fall && !pd_s |=> ramp_down_out)
    else $error("falling trigger did not start the down-ramp");
  partial_hold_a: assert property (qrs_seen |=> regulator_partial_out)
    else $error("regulator not held partially active after quick restart");
  level_apply_a: assert property (start_up && !pd_s |=> power_level_out == $past(shadow_r))
    else $error("new power level not applied at burst start");
  burst_trigger_hold_a: assert property (st_r == ST_DN_E && burst_trigger_rise && !pd_s
    |=> pending_r && !ramp_up_out)
    else $error("early rising trigger was not held until point G");

  // B to C and E to G span more than a thousand core cycles, so covers watch the closing edge.
  full_burst_c: cover property ((st_r == ST_UP_C && st_nxt == ST_HIGH) ##1 point_c_out);
  down_ramp_c: cover property ((st_r == ST_DN_G && hit_g) ##1 point_g_out);
  quick_restart_c: cover property (qrs_seen && dn_state);
  held_start_c: cover property (pending_r && start_up && st_r == ST_DN_G);

endmodule // burst_ramp_trigger_sequencer

// >>> testbench/baseband_model.sv
`timescale 1ns/100ps
module baseband_model (
  input wire logic core_clk_in,
  output logic master_clk_out,
  output logic trigger_out,
  output logic power_down_out,
  output logic sclk_out,
  output logic strobe_out,
  output logic sdata_out
);
  initial begin
    master_clk_out = 1'b0;
    trigger_out = 1'b0;
    power_down_out = 1'b1;
    sclk_out = 1'b0;
    strobe_out = 1'b1;
    sdata_out = 1'b0;
  end

  // ==========================================================================
  // Master clock
  // ==========================================================================
  // It runs free, offset from the core clock so no edge lands on a core edge.
  initial begin
    #13;
    forever #40 master_clk_out = ~master_clk_out;
  end

  // ==========================================================================
  // Controller actions
  // ==========================================================================
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  task automatic wake();
    @(negedge core_clk_in);
    power_down_out = 1'b0;
    idle(50000);
  endtask

  task automatic set_trigger(input logic v);
    @(negedge core_clk_in);
    trigger_out = v;
  endtask

  task automatic enter_power_down();
    @(negedge core_clk_in);
    power_down_out = 1'b1;
  endtask

  // The serial clock stands still outside a transfer, and the data line shows
  // the inverse of its last bit so that a late sample cannot look right.
  task automatic load_level(input logic [7:0] v);
    @(negedge core_clk_in);
    strobe_out = 1'b0;
    idle(5);
    for (int i = 7; i >= 0; i--) begin
      sdata_out = v[i];
      idle(10);
      sclk_out = 1'b1;
      idle(10);
      sclk_out = 1'b0;
    end
    idle(5);
    strobe_out = 1'b1;
    idle(5);
    sclk_out = 1'b1;
    idle(10);
    sclk_out = 1'b0;
    sdata_out = ~v[0];
    idle(5);
  endtask
endmodule // baseband_model

// >>> testbench/burst_ramp_trigger_sequencer_tb_top.sv
`timescale 1ns/100ps
module burst_ramp_trigger_sequencer_tb_top;
  import burst_ramp_pkg::*;
  logic core_clk_in;
  logic reset_n_in;
  logic mclk, burst_trigger, pd, sclk, strobe, sdata;
  logic ramp_up, ramp_down, pt_b, pt_c, pt_e, pt_g, partial;
  logic [7:0] level;
  int bad_count;
  int n_tests;
  int cyc;

  baseband_model partner (
    .core_clk_in(core_clk_in), .master_clk_out(mclk), .trigger_out(burst_trigger),
    .power_down_out(pd), .sclk_out(sclk), .strobe_out(strobe), .sdata_out(sdata));

  burst_ramp_trigger_sequencer #(.LEVEL_W(8)) dut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .master_clock_input_in(mclk),
    .burst_trigger_in(burst_trigger), .power_down_input_in(pd), .serial_clk_in(sclk),
    .serial_strobe_in(strobe), .serial_data_in(sdata), .ramp_up_out(ramp_up),
    .ramp_down_out(ramp_down), .point_b_out(pt_b), .point_c_out(pt_c),
    .point_e_out(pt_e), .point_g_out(pt_g), .regulator_partial_out(partial),
    .power_level_out(level));

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  always @(negedge core_clk_in) cyc <= cyc + 1;

  // ==========================================================================
  // Checking helpers
  // ==========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic in_range(input int v, input int lo, input int hi, input string msg);
    check({7'h0, 1'(v >= lo && v <= hi)}, 8'h01, msg);
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: pick = ramp_up;
      1: pick = ramp_down;
      2: pick = pt_b;
      3: pick = pt_c;
      4: pick = pt_e;
      default: pick = pt_g;
    endcase
  endfunction

  // Returns the cycle stamp at which the chosen output was first seen high.
  task automatic wait_for(input int k, input int limit, output int t);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < limit) begin
      @(negedge core_clk_in);
      n++;
    end
    check({7'h0, pick(k)}, 8'h01, "awaited output never rose");
    t = cyc;
  endtask

  task close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic s_burst();
    int t0, t1, t2;
    partner.load_level(8'ha5);
    partner.set_trigger(1'b1);
    t0 = cyc;
    wait_for(0, 20, t1);
    in_range(t1 - t0, 3, 5, "up-ramp start latency");
    check(level, 8'ha5, "level not applied at burst start");
    wait_for(2, 200, t2);
    in_range(t2 - t1, 118, 138, "trigger to B delay");
    wait_for(3, 1200, t1);
    in_range(t1 - t2, 1079, 1081, "B to C delay");
  endtask

  task automatic s_quick_restart();
    int t0, t1;
    partner.set_trigger(1'b0);
    partner.idle(50);
    partner.set_trigger(1'b1);
    partner.idle(10);
    check({7'h0, partial}, 8'h01, "quick restart not seen");
    check({7'h0, ramp_down}, 8'h01, "down-ramp not running");
    wait_for(4, 200, t0);
    partner.load_level(8'h3c);
    check({7'h0, ramp_up}, 8'h00, "held rise started early");
    wait_for(5, 2400, t1);
    partner.idle(1);
    check({7'h0, ramp_up}, 8'h01, "held rise not resumed at G");
    check(level, 8'h3c, "reloaded level not applied");
    check({7'h0, partial}, 8'h01, "regulator hold dropped early");
    wait_for(2, 200, t0);
    partner.idle(2);
    check({7'h0, partial}, 8'h00, "regulator hold kept past B");
  endtask

  task automatic s_long_low();
    int t0, t1, t2;
    partner.set_trigger(1'b0);
    t0 = cyc;
    wait_for(4, 200, t1);
    in_range(t1 - t0, 121, 143, "trigger to E delay");
    partner.idle(150 - (t1 - t0));
    partner.set_trigger(1'b1);
    partner.idle(10);
    check({7'h0, partial}, 8'h00, "long low taken as quick restart");
    wait_for(5, 2400, t2);
    in_range(t2 - t1, 2279, 2281, "E to G delay");
    partner.idle(1);
    check({7'h0, ramp_down}, 8'h00, "down-ramp kept past G");
  endtask

  task automatic s_power_down();
    partner.enter_power_down();
    partner.idle(6);
    check({7'h0, ramp_up}, 8'h00, "power-down left up-ramp on");
    check({7'h0, ramp_down}, 8'h00, "power-down left down-ramp on");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    bad_count = 0;
    n_tests = 0;
    reset_n_in = 1'b0;
    repeat (6) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    @(negedge core_clk_in);
    check({6'h0, ramp_up, ramp_down}, 8'h00, "outputs active after reset");
    partner.wake();
    s_burst();
    s_quick_restart();
    s_long_low();
    s_power_down();
    close_out();
  end

  // Longer than the full sequence, including the wake-up wait, by a wide margin.
  initial begin
    #640000;
    bad_count++;
    close_out();
  end
endmodule // burst_ramp_trigger_sequencer_tb_top
